// ==== rtl/ext_bus_pkg.sv ====
package ext_bus_pkg;
   localparam int NUM_REGS = 10;
   localparam int REG_W    = 16;
   localparam int DATA_W   = 32;
   localparam int ADDR_W   = 32;
   localparam int OFS_W    = 25;

   // register word addresses, reset values, write key
   localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
      32'h0FFFFFC0, 32'h0FFFFFC4, 32'h0FFFFFE0, 32'h0FFFFFE4, 32'h0FFFFFE8,
      32'h0FFFFFEC, 32'h0FFFFFF0, 32'h0FFFFFF8, 32'h0FFFFFFC, 32'hFFFFFFF4};
   localparam logic [REG_W-1:0] REG_RST [NUM_REGS] = '{
      16'h000B, 16'h0000, 16'h03F0, 16'h00FC, 16'hAAFF,
      16'h0000, 16'h0000, 16'h0000, 16'h0F00, 16'h0000};
   localparam int IDX_WAIT_CTRL_2      = 0;
   localparam int IDX_WAIT_CTRL_3      = 1;
   localparam int IDX_BUS_CTRL_1       = 2;
   localparam int IDX_BUS_CTRL_2       = 3;
   localparam int IDX_WAIT_CTRL_1      = 4;
   localparam int IDX_MEMORY_TYPE_CTRL = 5;
   localparam int IDX_REFRESH_CTRL     = 6;
   localparam int IDX_REFRESH_CONST    = 7;
   localparam int IDX_BUS_CTRL_3       = 8;
   localparam int IDX_REFRESH_COUNTER  = 9;

   localparam logic [REG_W-1:0]  WRITE_KEY = 16'hA55A;
   localparam logic [ADDR_W-1:0] HALF_OFS  = 32'h00000002;
   localparam logic [3:0]        BE_WORD   = 4'hF;
   localparam logic [3:0]        BE_HALF   = 4'h3;

   // memory type field of bus_ctrl_1
   localparam int DRAM_LSB = 0;

   // address decode fields
   localparam int          SPACE_LSB  = 25;
   localparam int          CT_BIT     = 29;
   localparam int          PAGE_LSB   = 12;
   localparam logic [2:0]  NUM_SPACES = 3'h5;
   localparam logic [1:0]  TOP_EXT    = 2'h0;
   localparam logic [2:0]  TOP_PURGE  = 3'h2;
   localparam logic [2:0]  TOP_ADDR_ARR = 3'h3;
   localparam logic [19:0] PG_XRAM    = 20'h1000E;
   localparam logic [19:0] PG_YRAM    = 20'h1001E;
   localparam logic [19:0] PG_DATA_ARR = 20'hC0000;
   localparam logic [19:0] PG_SDMODE0 = 20'hFFFF0;
   localparam logic [19:0] PG_SDMODE1 = 20'hFFFF8;
endpackage

// ==== rtl/external_bus_controller.sv ====
// How it works
// R1: every controller register keeps exactly sixteen bits of state
// R2: word reads return the register in low half, upper half zero
// R3: word writes land only when upper sixteen data bits equal the key
// R4: half-word accesses read only; half-word writes change nothing
// R5: half-word address of each register is its word address plus two
// R6: software touches only space zero until memory settings are programmed
// R7: reset loads the three bus control registers with their initial values
// R8: reset loads the three wait control registers with their initial values
// R9: reset clears memory type, refresh control, counter and constant
// R10: spaces zero and one decoded as 32-Mbyte blocks from address zero
// R11: spaces two, three and four decoded at their fixed bases
// R12: cache-through addresses reach the same external memory as cached ones
// R13: two 4-kbyte windows route to on-chip X and Y RAM
// R14: purge, address array and data array spaces go to cache control
// R15: both 4-kbyte SDRAM mode windows decode as mode programming
// R16: SDRAM in space two always uses auto-precharge
// R17: SDRAM in space three may keep a bank open
// R18: software never accesses reserved regions
// R19: rejected register writes still complete normally on the bus
// R20: only the decoded space's select is asserted during the cycle
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module external_bus_controller
   import ext_bus_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [DATA_W-1:0] writedata,
   output logic      [DATA_W-1:0] readdata,
   output logic                   waitrequest,
   input  wire logic              acc_valid,
   input  wire logic [ADDR_W-1:0] acc_addr,
   output logic                   space_zero_select,
   output logic                   space_one_select,
   output logic                   space_two_select,
   output logic                   space_three_select,
   output logic                   space_four_select,
   output logic                   cache_through,
   output logic      [OFS_W-1:0]  ext_offset,
   output logic                   xram_select,
   output logic                   yram_select,
   output logic                   purge_select,
   output logic                   addr_array_select,
   output logic                   data_array_select,
   output logic                   sdram_mode_select,
   output logic                   auto_precharge,
   output logic                   bank_active_ok
);

   logic [REG_W-1:0]  regs_r [NUM_REGS];
   logic [NUM_REGS-1:0] hit_word;
   logic [NUM_REGS-1:0] hit_half;
   logic              req;
   logic              done;
   logic              word_wr;
   logic [DATA_W-1:0] rd_nxt;
   logic [2:0]        dram_mode;
   logic              cs2_sdram;
   logic              cs3_sdram;
   logic [2:0]        space_idx;
   logic              ext_hit;
   logic [4:0]        cs_nxt;
   logic [19:0]       page;

   assign req  = read | write;
   assign done = req & ~waitrequest;

   // read path packs one register into the low half of a bus word;
   // the external offset must span exactly one space
   if (DATA_W != 2 * REG_W) begin : g_bad_width
      $error("bus word is not two registers wide");
   end
   if (OFS_W != SPACE_LSB) begin : g_bad_offset
      $error("offset width does not match the space size");
   end
   if (NUM_REGS < 1 || PAGE_LSB >= SPACE_LSB) begin : g_bad_map
      $error("register map or page size does not fit");
   end

   // one wait state: request sampled, answered the next edge
   // R19: always completes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~(req & waitrequest);
      end
   end

   // R5: half-word alias at plus two
   for (genvar i = 0; i < NUM_REGS; i++) begin : g_hit
      assign hit_word[i] = (address == REG_OFS[i]) && (byteenable == BE_WORD);
      assign hit_half[i] = (address == REG_OFS[i] + HALF_OFS) && (byteenable == BE_HALF);
   end

   // R3: keyed word write only
   // R4: no half-word write path
   assign word_wr = done & write & (writedata[DATA_W-1:REG_W] == WRITE_KEY);

   // R1: sixteen bits per register
   // R7: bus control reset values
   // R8: wait control reset values
   // R9: cleared registers
   for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            regs_r[i] <= REG_RST[i];
         end else if (word_wr && hit_word[i]) begin
            regs_r[i] <= writedata[REG_W-1:0];
         end
      end
   end

   // R2: upper half reads zero
   always_comb begin
      rd_nxt = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit_word[i] || hit_half[i]) begin
            rd_nxt = {{(DATA_W-REG_W){1'b0}}, regs_r[i]};
         end
      end
   end

   // unmapped reads return zero; data held through the answer cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readdata <= '0;
      end else if (read && waitrequest) begin
         readdata <= rd_nxt;
      end
   end

   // memory type of spaces two and three steers the SDRAM policy
   assign dram_mode = regs_r[IDX_BUS_CTRL_1][DRAM_LSB +: 3];
   assign cs2_sdram = dram_mode[2] & ~dram_mode[1];
   assign cs3_sdram = dram_mode[0] & ~dram_mode[1];

   assign space_idx = acc_addr[SPACE_LSB +: 3];
   assign page      = acc_addr[ADDR_W-1:PAGE_LSB];
   // R12: alias bit ignored for space index
   assign ext_hit   = (acc_addr[ADDR_W-1 -: 2] == TOP_EXT) && !acc_addr[CT_BIT-1]
                      && (space_idx < NUM_SPACES);

   // R10: spaces zero and one
   // R11: spaces two to four
   always_comb begin
      cs_nxt = '0;
      if (acc_valid && ext_hit) begin
         cs_nxt[space_idx] = 1'b1;
      end
   end

   // R20: selects follow the request, one at a time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         space_zero_select  <= 1'b0;
         space_one_select   <= 1'b0;
         space_two_select   <= 1'b0;
         space_three_select <= 1'b0;
         space_four_select  <= 1'b0;
      end else begin
         space_zero_select  <= cs_nxt[0];
         space_one_select   <= cs_nxt[1];
         space_two_select   <= cs_nxt[2];
         space_three_select <= cs_nxt[3];
         space_four_select  <= cs_nxt[4];
      end
   end

   // R12: same offset in either alias
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cache_through <= 1'b0;
         ext_offset    <= '0;
      end else begin
         cache_through <= acc_valid & ext_hit & acc_addr[CT_BIT];
         ext_offset    <= acc_addr[OFS_W-1:0];
      end
   end

   // R13: on-chip RAM windows
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xram_select <= 1'b0;
         yram_select <= 1'b0;
      end else begin
         xram_select <= acc_valid && (page == PG_XRAM);
         yram_select <= acc_valid && (page == PG_YRAM);
      end
   end

   // R14: cache control spaces
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         purge_select      <= 1'b0;
         addr_array_select <= 1'b0;
         data_array_select <= 1'b0;
      end else begin
         purge_select      <= acc_valid && (acc_addr[ADDR_W-1 -: 3] == TOP_PURGE)
                              && !acc_addr[CT_BIT-1] && (space_idx < NUM_SPACES);
         addr_array_select <= acc_valid && (acc_addr[ADDR_W-1 -: 3] == TOP_ADDR_ARR);
         data_array_select <= acc_valid && (page == PG_DATA_ARR);
      end
   end

   // R15: SDRAM mode windows
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sdram_mode_select <= 1'b0;
      end else begin
         sdram_mode_select <= acc_valid && ((page == PG_SDMODE0) || (page == PG_SDMODE1));
      end
   end

   // space two never leaves a bank open, space three may
   // R16: forced auto-precharge
   // R17: bank-active allowed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_precharge <= 1'b0;
         bank_active_ok <= 1'b0;
      end else begin
         auto_precharge <= cs_nxt[2] & cs2_sdram;
         bank_active_ok <= cs_nxt[3] & cs3_sdram;
      end
   end

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic rst_seen_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_seen_r <= 1'b1;
      end else begin
         rst_seen_r <= 1'b0;
      end
   end

   answer_next_a: assert property ( // R19
      (req && waitrequest) |=> !waitrequest)
      else $error("request not answered in one cycle");

   upper_zero_a: assert property ( // R2
      (read && !waitrequest) |-> (readdata[DATA_W-1:REG_W] == '0))
      else $error("upper read half not zero");

   half_read_a: assert property ( // R5
      (read && !waitrequest && address == REG_OFS[IDX_BUS_CTRL_1] + HALF_OFS
       && byteenable == BE_HALF) |-> (readdata[REG_W-1:0] == regs_r[IDX_BUS_CTRL_1]))
      else $error("half-word read wrong value");

   key_accept_a: assert property ( // R3
      (write && !waitrequest && hit_word[IDX_WAIT_CTRL_1]
       && writedata[DATA_W-1:REG_W] == WRITE_KEY)
      |=> (regs_r[IDX_WAIT_CTRL_1] == $past(writedata[REG_W-1:0])))
      else $error("keyed write not stored");

   key_reject_a: assert property ( // R3
      (write && !waitrequest && writedata[DATA_W-1:REG_W] != WRITE_KEY)
      |=> $stable(regs_r[IDX_WAIT_CTRL_1]) && $stable(regs_r[IDX_BUS_CTRL_3]))
      else $error("unkeyed write changed a register");

   half_write_a: assert property ( // R4
      (write && !waitrequest && byteenable == BE_HALF) |=> $stable(regs_r[IDX_BUS_CTRL_1]))
      else $error("half-word write changed a register");

   bus_reset_a: assert property ( // R7
      rst_seen_r |-> (regs_r[IDX_BUS_CTRL_1] == REG_RST[IDX_BUS_CTRL_1]
       && regs_r[IDX_BUS_CTRL_2] == REG_RST[IDX_BUS_CTRL_2]
       && regs_r[IDX_BUS_CTRL_3] == REG_RST[IDX_BUS_CTRL_3]))
      else $error("bus control reset value wrong");

   wait_reset_a: assert property ( // R8
      rst_seen_r |-> (regs_r[IDX_WAIT_CTRL_1] == REG_RST[IDX_WAIT_CTRL_1]
       && regs_r[IDX_WAIT_CTRL_2] == REG_RST[IDX_WAIT_CTRL_2]
       && regs_r[IDX_WAIT_CTRL_3] == REG_RST[IDX_WAIT_CTRL_3]))
      else $error("wait control reset value wrong");

   clear_reset_a: assert property ( // R9
      rst_seen_r |-> (regs_r[IDX_MEMORY_TYPE_CTRL] == '0 && regs_r[IDX_REFRESH_CTRL] == '0
       && regs_r[IDX_REFRESH_CONST] == '0 && regs_r[IDX_REFRESH_COUNTER] == '0))
      else $error("cleared register not zero after reset");

   space_one_a: assert property ( // R10
      (acc_valid && acc_addr[ADDR_W-1 -: 7] == 7'h01) |=> space_one_select)
      else $error("space one not selected");

   space_four_a: assert property ( // R11
      (acc_valid && acc_addr[ADDR_W-1 -: 7] == 7'h04) |=> space_four_select)
      else $error("space four not selected");

   alias_offset_a: assert property ( // R12
      (acc_valid && acc_addr[ADDR_W-1 -: 7] == 7'h12)
      |=> space_two_select && cache_through && ext_offset == $past(acc_addr[OFS_W-1:0]))
      else $error("cache-through alias mismatch");

   one_select_a: assert property ( // R20
      $onehot0({space_zero_select, space_one_select, space_two_select,
                space_three_select, space_four_select}))
      else $error("more than one space select");

   ram_window_a: assert property ( // R13
      (acc_valid && page == PG_YRAM) |=> yram_select && !xram_select && !space_zero_select)
      else $error("Y RAM window not decoded");

   cache_space_a: assert property ( // R14
      (acc_valid && acc_addr[ADDR_W-1 -: 3] == TOP_ADDR_ARR)
      |=> addr_array_select && !space_three_select)
      else $error("address array space not decoded");

   mode_window_a: assert property ( // R15
      (acc_valid && page == PG_SDMODE1) |=> sdram_mode_select)
      else $error("SDRAM mode window not decoded");

   precharge_two_a: assert property ( // R16
      (acc_valid && ext_hit && space_idx == 3'h2 && cs2_sdram) |=> auto_precharge && !bank_active_ok)
      else $error("space two SDRAM without auto-precharge");

   bank_three_a: assert property ( // R17
      (acc_valid && ext_hit && space_idx == 3'h3 && cs3_sdram) |=> bank_active_ok && !auto_precharge)
      else $error("space three SDRAM bank-active missing");

   idle_wait_a: assert property ( // R19
      !req |=> waitrequest)
      else $error("waitrequest low without a request");

   offset_follow_a: assert property ( // R12
      1'b1 |=> ext_offset == $past(acc_addr[OFS_W-1:0]))
      else $error("external offset does not follow the access");

   select_drop_a: assert property ( // R20
      !acc_valid |=> !space_zero_select && !space_one_select && !space_two_select
                     && !space_three_select && !space_four_select)
      else $error("space select held without an access");

   keyed_write_c: cover property (write && !waitrequest && word_wr);
   half_read_c: cover property (read && !waitrequest && |hit_half);
   through_c: cover property (cache_through && space_two_select);
   mode_c: cover property (sdram_mode_select);
   reject_c: cover property (done && write && !word_wr);

endmodule

// ==== testbench/access_master.sv ====
`timescale 1ns/10ps
module access_master (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        req,
   input  wire logic [31:0] req_addr,
   output logic             acc_valid,
   output logic [31:0]      acc_addr
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_valid <= 1'b0;
         acc_addr  <= 32'h0;
      end else if (req) begin
         acc_valid <= 1'b1;
         acc_addr  <= req_addr;
      end else begin
         acc_valid <= 1'b0;
         // released bus must not look like a held address
         acc_addr  <= ~acc_addr;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench
   import ext_bus_pkg::*;
;
   typedef struct packed {logic [31:0] a; logic [13:0] s;} row_t;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic        req = 1'b0;
   logic [31:0] address = 32'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] req_addr = 32'h0;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] readdata;
   logic [31:0] acc_addr;
   logic [31:0] rd;
   logic        waitrequest;
   logic        acc_valid;
   wire  [13:0] sel;
   logic [24:0] ext_offset;
   int          err_total = 0;
   int          checks_done = 0;
   row_t        rows [13];

   always #10 clk = ~clk;

   access_master partner (.clk(clk), .reset_n(reset_n), .req(req), .req_addr(req_addr),
      .acc_valid(acc_valid), .acc_addr(acc_addr));

   external_bus_controller DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .acc_valid(acc_valid), .acc_addr(acc_addr),
      .space_zero_select(sel[13]), .space_one_select(sel[12]), .space_two_select(sel[11]),
      .space_three_select(sel[10]), .space_four_select(sel[9]), .cache_through(sel[8]),
      .ext_offset(ext_offset), .xram_select(sel[7]), .yram_select(sel[6]),
      .purge_select(sel[5]), .addr_array_select(sel[4]), .data_array_select(sel[3]),
      .sdram_mode_select(sel[2]), .auto_precharge(sel[1]), .bank_active_ok(sel[0]));

   task automatic stop_test;
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one Avalon transfer; waits for waitrequest low, the watchdog bounds it
   task automatic bus(input logic wr, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      byteenable <= be;
      writedata <= d;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // decode lags the partner by one edge; checked on the second held cycle
   task automatic probe(input logic [31:0] a, input logic [13:0] exp);
      @(posedge clk);
      req <= 1'b1;
      req_addr <= a;
      repeat (3) @(posedge clk);
      req <= 1'b0;
      #1;
      chk(32'(sel), 32'(exp));
      chk(32'(ext_offset), 32'(a[24:0]));
   endtask

   initial begin
      #100000;
      err_total++;
      stop_test();
   end

   initial begin
      rows = '{'{32'h00000000, 14'h2000}, '{32'h02000000, 14'h1000}, '{32'h04000000, 14'h0800},
               '{32'h06000000, 14'h0400}, '{32'h09FFFFFC, 14'h0200}, '{32'h21FFFFFC, 14'h2100},
               '{32'h28000000, 14'h0300}, '{32'h1000E000, 14'h0080}, '{32'h1001EFFC, 14'h0040},
               '{32'h40000000, 14'h0020}, '{32'h60000000, 14'h0010}, '{32'hC0000FFC, 14'h0008},
               '{32'hFFFF8FFC, 14'h0004}};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
         bus(1'b0, REG_OFS[i], BE_WORD, 32'h0);
         chk(rd, {16'h0, REG_RST[i]});
         bus(1'b1, REG_OFS[i], BE_WORD, {WRITE_KEY, 16'hC3A0 ^ 16'(i)});
         bus(1'b0, REG_OFS[i] + HALF_OFS, BE_HALF, 32'h0);
         chk(rd[15:0], 16'hC3A0 ^ 16'(i));
      end
      foreach (rows[i])
         probe(rows[i].a, rows[i].s);
      probe(32'hFFFF0000, 14'h0004);
      // rejected writes must leave the value and still complete
      bus(1'b1, REG_OFS[IDX_BUS_CTRL_1], BE_WORD, 32'h5AA5FFFF);
      bus(1'b1, REG_OFS[IDX_BUS_CTRL_1] + HALF_OFS, BE_HALF, 32'h0000FFFF);
      bus(1'b0, REG_OFS[IDX_BUS_CTRL_1], BE_WORD, 32'h0);
      chk(rd, 32'h0000C3A2);
      bus(1'b0, 32'h0FFFFFC8, BE_WORD, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, REG_OFS[IDX_BUS_CTRL_1], BE_WORD, 32'hA55A0004);
      probe(32'h04000000, 14'h0802);
      probe(32'h06000000, 14'h0400);
      bus(1'b1, REG_OFS[IDX_BUS_CTRL_1], BE_WORD, 32'hA55A0001);
      probe(32'h26000000, 14'h0501);
      probe(32'h24000000, 14'h0900);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, REG_OFS[IDX_BUS_CTRL_1], BE_WORD, 32'h0);
      chk(rd, 32'h000003F0);
      bus(1'b0, REG_OFS[IDX_WAIT_CTRL_1] + HALF_OFS, BE_HALF, 32'h0);
      chk(rd[15:0], 16'hAAFF);
      stop_test();
   end
endmodule
